// ===== design/psal_consts.vh
// constants for the status latch and alert block
// Contract
// (RULE_01) every status latch except output-off and power-good stays set until an explicit clear
// (RULE_02) output-off and power-good-negated bits are live, never latched or cleared
// (RULE_03) status byte write clears bits holding 1, leaves bits holding 0
// (RULE_04) lower-level status registers clear by write; summary registers cannot
// (RULE_05) summary bits are the OR of their latches, clearing in the same cycle
// (RULE_06) clear-faults command and output off-then-on cycle also clear all latches
// (RULE_07) a clear while the event persists re-sets the latch at once
// (RULE_08) clearing is a one-cycle pulse, never a held reset
// (RULE_09) an unmasked re-set latch reasserts the alert right after the clear
// (RULE_10) each latch reaches the alert only while its mask bit is zero
// (RULE_11) alert goes low on an unmasked latch rising and stays until cleared
// (RULE_12) alert releases after own address is sent answering the alert response read
// (RULE_13) clear-faults command also deasserts the alert
// (RULE_14) alert response answered only when base address is 40h or more
// (RULE_15) clears act only when the write transaction ends acknowledged
// (RULE_16) power-on reset clears all latches, summaries and the alert
`ifndef PSAL_CONSTS_VH
`define PSAL_CONSTS_VH
`define PSAL_NGRP        4
`define PSAL_NBITS       32
`define PSAL_GRP_VOUT    2'h0
`define PSAL_GRP_IOUT    2'h1
`define PSAL_GRP_TEMP    2'h2
`define PSAL_GRP_CML     2'h3
`define PSAL_WORD_VOUT   15
`define PSAL_WORD_IOUT   14
`define PSAL_WORD_PGN    11
`define PSAL_WORD_OFF    6
`define PSAL_WORD_TEMP   2
`define PSAL_WORD_CML    1
`define PSAL_LAT_RST     32'h0000_0000
`define PSAL_WORD_RST    16'h0000
`define PSAL_ARA_ADDR    7'h0c
`define PSAL_ARA_MIN     7'h40
`define PSAL_TX_BITS     4'h8
`endif

// ===== design/psal_ara_resp.v
// alert response address responder sampling the link pins
`timescale 1ns/10ps
`default_nettype none
`include "psal_consts.vh"
module psal_ara_resp (
    // clock and reset
    input  wire       core_clk,
    input  wire       rst_n,
    // link pins
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_oe_q,
    // control
    input  wire       arm,
    input  wire [6:0] own_addr,
    output reg        done_q
);
    localparam S_IDLE = 5'b00001;
    localparam S_ADDR = 5'b00010;
    localparam S_ACK  = 5'b00100;
    localparam S_TX   = 5'b01000;
    localparam S_MACK = 5'b10000;

    reg  [4:0] state_q;
    reg  [7:0] sh_q;
    reg  [3:0] cnt_q;
    reg  [1:0] scl_m_q;
    reg  [1:0] sda_m_q;
    reg        scl_p_q;
    reg        sda_p_q;
    wire       scl_s = scl_m_q[1];
    wire       sda_s = sda_m_q[1];
    wire       scl_rise = scl_s & ~scl_p_q;
    wire       scl_fall = ~scl_s & scl_p_q;
    wire       start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    wire       stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

    // pins cross two flops; the edge finders only see the second
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_m_q <= 2'h3;
            sda_m_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_m_q <= {scl_m_q[0], scl_in};
            sda_m_q <= {sda_m_q[0], sda_in};
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q  <= S_IDLE;
            sh_q     <= 8'h00;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start) begin
                state_q  <= S_ADDR;
                cnt_q    <= 4'h0;
                sda_oe_q <= 1'b0;
            end else if (stop) begin
                state_q  <= S_IDLE;
                sda_oe_q <= 1'b0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        sda_oe_q <= 1'b0;
                    end
                    S_ADDR: begin
                        if (scl_rise) begin
                            sh_q  <= {sh_q[6:0], sda_s};
                            cnt_q <= cnt_q + 4'h1;
                        end else if (scl_fall && cnt_q == `PSAL_TX_BITS) begin
                            if (sh_q == {`PSAL_ARA_ADDR, 1'b1} && arm) begin
                                state_q  <= S_ACK;
                                sda_oe_q <= 1'b1;
                            end else begin
                                state_q <= S_IDLE;
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            state_q  <= S_TX;
                            sh_q     <= {own_addr, 1'b0};
                            sda_oe_q <= ~own_addr[6];
                            cnt_q    <= 4'h0;
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            // a released one read back low means another target won
                            if (!sda_oe_q && !sda_s) begin
                                state_q <= S_IDLE;
                            end else begin
                                cnt_q <= cnt_q + 4'h1;
                            end
                        end else if (scl_fall) begin
                            if (cnt_q == `PSAL_TX_BITS) begin
                                state_q  <= S_MACK;
                                sda_oe_q <= 1'b0;
                            end else begin
                                sh_q     <= {sh_q[6:0], 1'b0};
                                sda_oe_q <= ~sh_q[6];
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            done_q  <= 1'b1; // [RULE_12]
                            state_q <= S_IDLE;
                        end
                    end
                    default: begin
                        state_q  <= S_IDLE;
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // psal_ara_resp
`default_nettype wire

// ===== design/psal_alert_latch.v
// status latches, summary word and alert output of the power-management target
`timescale 1ns/10ps
`default_nettype none
`include "psal_consts.vh"
module psal_alert_latch (
    // clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // event detectors and live state, asynchronous
    input  wire [31:0] evt_in,
    input  wire        output_in_regulation,
    input  wire        en_pin,
    // command decoder, core clock domain
    input  wire        operation_on,
    input  wire        wr_status_stb,
    input  wire [1:0]  wr_status_grp,
    input  wire [7:0]  wr_status_data,
    input  wire        clear_faults_stb,
    input  wire        txn_end,
    input  wire        txn_ok,
    // configuration
    input  wire [31:0] alert_mask,
    input  wire [6:0]  base_addr,
    input  wire [6:0]  slave_addr,
    // link pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output wire        sda_oe,
    output reg         alert_out_n,
    output reg         alert_oe,
    // status read back
    output reg  [31:0] status_lat,
    output reg  [15:0] status_word
);
    reg  [31:0] evt_m_q;
    reg  [31:0] evt_s_q;
    reg  [1:0]  pg_m_q;
    reg  [1:0]  en_m_q;
    reg  [31:0] lat_q;
    reg  [31:0] unm_q;
    reg  [31:0] pend_mask_q;
    reg         pend_cf_q;
    reg         out_on_q;
    reg         alert_q;
    wire        ara_done;
    wire        pg_s = pg_m_q[1];
    wire        out_on_d = en_m_q[1] & operation_on;
    // an off-then-on cycle shows as the rising edge of the combined enable
    wire        onoff_clr = out_on_d & ~out_on_q; // [RULE_06]
    wire        commit = txn_end & txn_ok; // [RULE_15]
    wire        cf_clr = commit & pend_cf_q;
    wire [31:0] clr_mask;
    wire [31:0] lat_d;
    wire [31:0] unm_d;
    wire [31:0] rise;
    wire        arm = alert_q & (base_addr >= `PSAL_ARA_MIN); // [RULE_14]
    wire        alert_d;
    wire [15:0] word_d;

    // clear strobe lasts one cycle, so a live detector wins in that very cycle
    assign clr_mask = ({32{commit}} & pend_mask_q) | {32{cf_clr | onoff_clr}}; // [RULE_08] [RULE_06]

    genvar i;
    generate
        for (i = 0; i < `PSAL_NBITS; i = i + 1) begin : g_bit
            assign lat_d[i] = (lat_q[i] & ~clr_mask[i]) | evt_s_q[i]; // [RULE_01] [RULE_07]
            assign unm_d[i] = lat_d[i] & ~alert_mask[i]; // [RULE_10]
            // a clear on a still-set bit counts as a fresh edge
            assign rise[i]  = unm_d[i] & (~unm_q[i] | clr_mask[i]); // [RULE_09] [RULE_11]
        end
    endgenerate

    // set beats both clears
    assign alert_d = (|rise) | (alert_q & ~ara_done & ~cf_clr); // [RULE_11] [RULE_12] [RULE_13]

    assign word_d = ({16{|lat_d[8*`PSAL_GRP_VOUT+:8]}} & (16'h0001 << `PSAL_WORD_VOUT))
                  | ({16{|lat_d[8*`PSAL_GRP_IOUT+:8]}} & (16'h0001 << `PSAL_WORD_IOUT))
                  | ({16{|lat_d[8*`PSAL_GRP_TEMP+:8]}} & (16'h0001 << `PSAL_WORD_TEMP))
                  | ({16{|lat_d[8*`PSAL_GRP_CML+:8]}}  & (16'h0001 << `PSAL_WORD_CML))
                  | ({16{~pg_s}}     & (16'h0001 << `PSAL_WORD_PGN))
                  | ({16{~out_on_d}} & (16'h0001 << `PSAL_WORD_OFF)); // [RULE_05] [RULE_02]

    // asynchronous inputs pass two flops first
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_m_q <= 32'h0000_0000;
            evt_s_q <= 32'h0000_0000;
            pg_m_q  <= 2'h0;
            en_m_q  <= 2'h0;
        end else begin
            evt_m_q <= evt_in;
            evt_s_q <= evt_m_q;
            pg_m_q  <= {pg_m_q[0], output_in_regulation};
            en_m_q  <= {en_m_q[0], en_pin};
        end
    end

    // clears wait for the acknowledged end of the transaction; an abort drops them
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_mask_q <= 32'h0000_0000;
            pend_cf_q   <= 1'b0;
        end else if (txn_end) begin
            pend_mask_q <= 32'h0000_0000; // [RULE_15]
            pend_cf_q   <= 1'b0;
        end else begin
            // only lower-level groups are addressable; summaries have no write path
            if (wr_status_stb) begin
                pend_mask_q <= pend_mask_q
                             | ({24'h000000, wr_status_data} << {wr_status_grp, 3'h0}); // [RULE_03] [RULE_04]
            end
            if (clear_faults_stb) begin
                pend_cf_q <= 1'b1;
            end
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_q       <= `PSAL_LAT_RST; // [RULE_16]
            unm_q       <= 32'h0000_0000;
            out_on_q    <= 1'b0;
            alert_q     <= 1'b0;
            status_lat  <= `PSAL_LAT_RST;
            status_word <= `PSAL_WORD_RST;
            alert_out_n <= 1'b1;
            alert_oe    <= 1'b0;
            sda_out     <= 1'b0;
        end else begin
            lat_q       <= lat_d;
            unm_q       <= unm_d;
            out_on_q    <= out_on_d;
            alert_q     <= alert_d;
            status_lat  <= lat_d;
            status_word <= word_d; // [RULE_05]
            alert_out_n <= ~alert_d;
            alert_oe    <= alert_d;
            sda_out     <= 1'b0;
        end
    end

    psal_ara_resp u_ara (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_oe_q (sda_oe),
        .arm      (arm),
        .own_addr (slave_addr),
        .done_q   (ara_done)
    );
endmodule // psal_alert_latch
`default_nettype wire

// ===== tb/psal_alert_latch_chk.sv
// checker bound to the status latch and alert block
`timescale 1ns/10ps
`default_nettype none
module psal_alert_latch_chk (
    // watched ports
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic        operation_on,
    input wire logic        en_pin,
    input wire logic        txn_end,
    input wire logic        txn_ok,
    input wire logic [31:0] alert_mask,
    input wire logic [6:0]  base_addr,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic        alert_out_n,
    input wire logic        alert_oe,
    input wire logic [31:0] status_lat,
    input wire logic [15:0] status_word
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [4:0] age_q;
    // cycles since the responder last pulled data low, saturating
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) age_q <= 5'h1f;
        else if (sda_oe) age_q <= 5'h00;
        else if (age_q != 5'h1f) age_q <= age_q + 5'h01;
    end
    chk_word_or: assert property (status_word[15:14] == {|status_lat[7:0], |status_lat[15:8]}
        && status_word[2:1] == {|status_lat[23:16], |status_lat[31:24]})
        else $error("summary differs from latch groups");
    chk_word_unused: assert property ((status_word & 16'h37b9) == 16'h0000)
        else $error("unused summary bit set");
    chk_latch_sticky: assert property (|($past(status_lat) & ~status_lat) |->
        $past(txn_end) && $past(txn_ok) || ($past(operation_on) && !$past(operation_on, 2))
        || ($past(en_pin, 3) && !$past(en_pin, 4))) else $error("latch dropped unasked");
    chk_abort_keep: assert property (txn_end && !txn_ok |=>
        ($past(status_lat) & ~status_lat) == 32'h0) else $error("aborted write cleared");
    chk_alert_set: assert property (|(status_lat & ~$past(status_lat) & ~alert_mask)
        |-> !alert_out_n) else $error("alert missed a new latch");
    chk_alert_cause: assert property ($fell(alert_out_n) |-> |(status_lat & ~alert_mask))
        else $error("alert without unmasked latch");
    chk_alert_hold: assert property ($rose(alert_out_n) |->
        ($past(txn_end) && $past(txn_ok)) || age_q < 5'd16) else $error("alert released unasked");
    chk_pin_pair: assert property (alert_oe == !alert_out_n && sda_out == 1'b0)
        else $error("pin enable disagrees with level");
    chk_ara_base: assert property (sda_oe |-> base_addr >= 7'h40)
        else $error("response below base limit");
    cov_relatch: cover property (txn_end && txn_ok && !alert_out_n);
    cov_ara: cover property ($rose(alert_out_n) && age_q < 5'd16);
    cov_masked: cover property (|(status_lat & alert_mask) && alert_out_n);
endmodule // psal_alert_latch_chk
bind psal_alert_latch psal_alert_latch_chk psal_alert_latch_chk_i (.core_clk, .rst_n,
    .operation_on, .en_pin, .txn_end, .txn_ok, .alert_mask, .base_addr, .sda_out, .sda_oe,
    .alert_out_n, .alert_oe, .status_lat, .status_word);
`default_nettype wire

// ===== tb/psal_host_model.sv
// smbus host model that runs the alert response read
`timescale 1ns/10ps
`default_nettype none
module psal_host_model (
    // link
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // one 400 ns bit; data moves only while the clock is low
    task automatic bit_x(input logic b, output logic r);
        sda_pull = !b;
        #150 scl = 1'b1;
        #100 r = sda;
        #100 scl = 1'b0;
        #50;
    endtask
    // clock stands still high outside the frame
    // lose pulls the first reply bit low, as a competing target would
    task automatic ara(input logic [7:0] a, input logic lose, output logic ack,
        output logic [7:0] rx);
        logic d;
        sda_pull = 1'b1;
        #200 scl = 1'b0;
        #50;
        for (int i = 7; i >= 0; i--) bit_x(a[i], d);
        bit_x(1'b1, ack);
        for (int i = 7; i >= 0; i--) bit_x(!(lose && i == 7), rx[i]);
        bit_x(1'b1, d);
        sda_pull = 1'b1;
        #150 scl = 1'b1;
        #100 sda_pull = 1'b0;
        #200;
    endtask
endmodule // psal_host_model
`default_nettype wire

// ===== tb/psal_alert_latch_tb.sv
// self-checking bench for the status latch and alert block
`timescale 1ns/10ps
`default_nettype none
`include "psal_consts.vh"
module psal_alert_latch_tb;
    logic        core_clk, rst_n, output_in_regulation, en_pin, operation_on, ack, scl;
    logic        wr_status_stb, clear_faults_stb, txn_end, txn_ok, sda_pull, sda_oe;
    logic        sda_out, alert_out_n, alert_oe;
    logic [1:0]  wr_status_grp;
    logic [7:0]  wr_status_data, rx;
    logic [31:0] evt_in, alert_mask, status_lat;
    logic [6:0]  base_addr;
    logic [15:0] status_word;
    int          error_cnt, cmp_count;
    wire         sda_line = !(sda_pull || sda_oe);
    localparam logic [6:0] slave_id = 7'h45;
    psal_alert_latch psal_alert_latch_i (.core_clk, .rst_n, .evt_in, .output_in_regulation,
        .en_pin, .operation_on, .wr_status_stb, .wr_status_grp, .wr_status_data,
        .clear_faults_stb, .txn_end, .txn_ok, .alert_mask, .base_addr, .slave_addr(slave_id),
        .scl_in(scl), .sda_in(sda_line), .sda_out, .sda_oe, .alert_out_n, .alert_oe,
        .status_lat, .status_word);
    psal_host_model psal_host_model_i (.scl, .sda_pull, .sda(sda_line));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = !core_clk;
    end
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %h", $time, msg, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // strobes first, then the end of the transfer, acked or aborted
    task automatic commit(input logic [1:0] g, input logic [7:0] d, input logic w, cf, ok);
        {wr_status_grp, wr_status_data, wr_status_stb, clear_faults_stb} = {g, d, w, cf};
        tick(1);
        {wr_status_stb, clear_faults_stb, txn_end, txn_ok} = {3'b001, ok};
        tick(1);
        txn_end = 1'b0;
    endtask
    task automatic pulse(input logic [31:0] e);
        evt_in = e;
        tick(2);
        evt_in = 32'h0;
        tick(3);
    endtask
    task automatic t_sticky;
        pulse(32'h11);
        chk(status_lat, 32'h11, "latched");
        chk({31'h0, alert_out_n}, 32'h0, "alert set");
        commit(2'h0, 8'h10, 1'b1, 1'b0, 1'b1);
        chk(status_lat, 32'h01, "bit clear");
        commit(2'h0, 8'h00, 1'b1, 1'b1, 1'b0);
        chk(status_lat, 32'h01, "aborted clear");
        commit(2'h0, 8'hff, 1'b1, 1'b0, 1'b1);
        chk({16'h0, status_word}, 32'h0, "summary off");
        chk({31'h0, alert_out_n}, 32'h0, "alert kept");
        commit(2'h0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk({31'h0, alert_out_n}, 32'h1, "alert cleared");
        $display("test sticky done");
    endtask
    task automatic t_groups;
        logic [15:0] w [4] = '{16'h8000, 16'h4000, 16'h0004, 16'h0002};
        alert_mask = 32'h8000_0000;
        for (int g = 0; g < 4; g++) begin
            pulse(32'h80 << (8 * g));
            chk({16'h0, status_word}, {16'h0, w[g]}, "summary");
            commit(2'(g), 8'h80, 1'b1, 1'b0, 1'b1);
            chk(status_lat, 32'h0, "group clear");
        end
        chk({31'h0, alert_out_n}, 32'h0, "masked path");
        commit(2'h0, 8'h00, 1'b0, 1'b1, 1'b1);
        pulse(32'h8000_0000);
        chk({31'h0, alert_out_n}, 32'h1, "masked alert");
        commit(2'h3, 8'h80, 1'b1, 1'b0, 1'b1);
        alert_mask = 32'h0;
        $display("test groups done");
    endtask
    task automatic t_relatch;
        evt_in = 32'h1;
        tick(4);
        commit(2'h0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(status_lat, 32'h1, "relatched");
        chk({31'h0, alert_out_n}, 32'h0, "alert again");
        evt_in = 32'h0;
        tick(3);
        commit(2'h0, 8'h00, 1'b0, 1'b1, 1'b1);
        chk(status_lat, 32'h0, "pulse clear");
        output_in_regulation = 1'b0;
        tick(4);
        commit(2'h0, 8'hff, 1'b1, 1'b1, 1'b1);
        chk({16'h0, status_word}, 32'h0800, "live output_in_regulation");
        output_in_regulation = 1'b1;
        pulse(32'h2);
        operation_on = 1'b0;
        tick(4);
        chk({16'h0, status_word}, 32'h8040, "live off");
        operation_on = 1'b1;
        tick(2);
        chk(status_lat, 32'h0, "off on clear");
        pulse(32'h4);
        en_pin = 1'b0;
        tick(5);
        en_pin = 1'b1;
        tick(5);
        chk(status_lat, 32'h0, "pin cycle clear");
        $display("test relatch done");
    endtask
    task automatic t_ara;
        base_addr = 7'h3f;
        psal_host_model_i.ara({`PSAL_ARA_ADDR, 1'b1}, 1'b0, ack, rx);
        tick(8);
        chk({31'h0, ack}, 32'h1, "low base no ack");
        chk({31'h0, alert_out_n}, 32'h0, "alert stays");
        base_addr = 7'h40;
        // a competing target wins the first reply bit, so the alert must stay
        psal_host_model_i.ara({`PSAL_ARA_ADDR, 1'b1}, 1'b1, ack, rx);
        tick(8);
        chk({31'h0, alert_out_n}, 32'h0, "lost arbitration keeps alert");
        psal_host_model_i.ara({`PSAL_ARA_ADDR, 1'b1}, 1'b0, ack, rx);
        tick(4);
        chk({23'h0, ack, rx}, {24'h0, slave_id, 1'b0}, "own address");
        chk({31'h0, alert_out_n}, 32'h1, "alert released");
        chk(status_lat, 32'h0, "latches kept clear");
        $display("test ara done");
    endtask
    initial begin
        {rst_n, evt_in, alert_mask, wr_status_stb, clear_faults_stb, txn_end, txn_ok} = '0;
        {output_in_regulation, en_pin, operation_on, wr_status_grp, wr_status_data} = '1;
        base_addr = 7'h40;
        repeat (8) @(posedge core_clk);
        #1 rst_n = 1'b1;
        tick(3);
        t_sticky;
        t_groups;
        t_relatch;
        t_ara;
        pulse(32'h1);
        rst_n = 1'b0;
        tick(1);
        chk(status_lat, 32'h0, "reset latches");
        chk({15'h0, status_word, alert_out_n}, 32'h1, "reset summary and alert");
        give_verdict;
    end
    initial begin
        #100000;
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule // psal_alert_latch_tb
`default_nettype wire
